/* File: src/rc_trim_pkg.sv */
package rc_trim_pkg;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [11:0] CAL_OFFSET     = 12'h000;
    localparam logic [11:0] OSC_SEL_OFFSET = 12'h004;
    localparam logic [11:0] STATUS_OFFSET  = 12'h008;

    // ==========================================================
    // Calibration field layout and reset
    // ==========================================================
    localparam int          FINE_MSB      = 7;
    localparam int          FINE_LSB      = 4;
    localparam int          UP_BIT        = 3;
    localparam int          DOWN_BIT      = 2;
    localparam logic [7:0]  CAL_RESET     = 8'h70;
    localparam logic [7:0]  CAL_WR_MASK   = 8'hFC;
    localparam logic [2:0]  OSC_SEL_RESET = 3'h7;

    // ==========================================================
    // Oscillator select codes
    // ==========================================================
    localparam logic [2:0]  SEL_INT_RC    = 3'h5;
    localparam logic [2:0]  SEL_EXT_RC    = 3'h7;
    localparam int          QUARTER_DIV   = 4;

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // Resolved coarse offset
    typedef enum logic [1:0] {
        COARSE_NONE = 2'b00,
        COARSE_UP   = 2'b01,
        COARSE_DOWN = 2'b10
    } coarse_t;

    typedef struct packed {
        logic [3:0] fine_trim_code;
        coarse_t    coarse;
    } trim_ctrl_t;

    typedef struct packed {
        logic [7:0]  rc_trim_calibration;
        logic [2:0]  oscillator_select_field;
        logic        aw_held;
        logic [11:0] aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [1:0]  div_cnt;
        logic        quarter_clock;
    } state_t;

endpackage : rc_trim_pkg

/* File: src/rc_oscillator_trim_control.sv */
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module rc_oscillator_trim_control (
    input  wire logic                    clk_sys_i,
    input  wire logic                    rstn_i,
    input  wire logic [11:0]             s_axi_awaddr_i,
    input  wire logic                    s_axi_awvalid_i,
    output logic                         s_axi_awready_o,
    input  wire logic [31:0]             s_axi_wdata_i,
    input  wire logic [3:0]              s_axi_wstrb_i,
    input  wire logic                    s_axi_wvalid_i,
    output logic                         s_axi_wready_o,
    output logic [1:0]                   s_axi_bresp_o,
    output logic                         s_axi_bvalid_o,
    input  wire logic                    s_axi_bready_i,
    input  wire logic [11:0]             s_axi_araddr_i,
    input  wire logic                    s_axi_arvalid_i,
    output logic                         s_axi_arready_o,
    output logic [31:0]                  s_axi_rdata_o,
    output logic [1:0]                   s_axi_rresp_o,
    output logic                         s_axi_rvalid_o,
    input  wire logic                    s_axi_rready_i,
    output rc_trim_pkg::trim_ctrl_t      trim_ctrl_o,
    output logic                         quarter_clock_output_o,
    output logic                         quarter_clock_enable_o
);

    rc_trim_pkg::state_t st;
    rc_trim_pkg::state_t next_st;
    logic                rc_mode;
    logic                wr_go;
    logic                rd_go;

    function automatic logic [31:0] read_word(input logic [11:0] a,
                                              input logic [7:0]  cal,
                                              input logic [2:0]  sel,
                                              input logic        en);
        read_word = 32'h0000_0000;
        unique case (a)
            rc_trim_pkg::CAL_OFFSET:     read_word = {24'h000000, cal};
            rc_trim_pkg::OSC_SEL_OFFSET: read_word = {29'h0000000, sel};
            rc_trim_pkg::STATUS_OFFSET:  read_word = {31'h00000000, en};
            default:                     read_word = 32'h0000_0000;
        endcase
    endfunction : read_word

    function automatic logic addr_ok(input logic [11:0] a);
        addr_ok = (a == rc_trim_pkg::CAL_OFFSET) || (a == rc_trim_pkg::OSC_SEL_OFFSET)
               || (a == rc_trim_pkg::STATUS_OFFSET);
    endfunction : addr_ok

    // ==========================================================
    // Trim decode
    // ==========================================================
    // mode gate
    assign rc_mode = (st.oscillator_select_field == rc_trim_pkg::SEL_INT_RC)
                  || (st.oscillator_select_field == rc_trim_pkg::SEL_EXT_RC);

    always_comb begin
        trim_ctrl_o.fine_trim_code = st.rc_trim_calibration[rc_trim_pkg::FINE_MSB:
                                                            rc_trim_pkg::FINE_LSB];
        if (st.rc_trim_calibration[rc_trim_pkg::UP_BIT]) begin
            trim_ctrl_o.coarse = rc_trim_pkg::COARSE_UP;
        end else if (st.rc_trim_calibration[rc_trim_pkg::DOWN_BIT]) begin
            trim_ctrl_o.coarse = rc_trim_pkg::COARSE_DOWN;
        end else begin
            trim_ctrl_o.coarse = rc_trim_pkg::COARSE_NONE;
        end
    end

    // ==========================================================
    // Bus handshake
    // ==========================================================
    assign s_axi_awready_o        = !st.aw_held && !st.bvalid;
    assign s_axi_wready_o         = !st.w_held && !st.bvalid;
    assign s_axi_arready_o        = !st.rvalid;
    assign s_axi_bvalid_o         = st.bvalid;
    assign s_axi_bresp_o          = st.bresp;
    assign s_axi_rvalid_o         = st.rvalid;
    assign s_axi_rdata_o          = st.rdata;
    assign s_axi_rresp_o          = st.rresp;
    assign quarter_clock_output_o = st.quarter_clock;
    assign quarter_clock_enable_o = rc_mode;

    assign wr_go = st.aw_held && st.w_held && !st.bvalid;
    assign rd_go = s_axi_arvalid_i && !st.rvalid;

    // ==========================================================
    // Next state and registers
    // ==========================================================
    always_comb begin
        next_st = st;
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata_i;
            next_st.w_strb = s_axi_wstrb_i;
        end
        if (wr_go) begin
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = addr_ok(st.aw_addr) ? rc_trim_pkg::RESP_OKAY
                                                  : rc_trim_pkg::RESP_SLVERR;
            if (st.aw_addr == rc_trim_pkg::CAL_OFFSET && st.w_strb[0]) begin
                next_st.rc_trim_calibration = st.w_data[7:0] & rc_trim_pkg::CAL_WR_MASK;
            end
            if (st.aw_addr == rc_trim_pkg::OSC_SEL_OFFSET && st.w_strb[0]) begin
                next_st.oscillator_select_field = st.w_data[2:0];
            end
        end else if (st.bvalid && s_axi_bready_i) begin
            next_st.bvalid = 1'b0;
        end
        if (rd_go) begin
            next_st.rvalid = 1'b1;
            next_st.rdata  = read_word(s_axi_araddr_i, st.rc_trim_calibration,
                                       st.oscillator_select_field, rc_mode);
            next_st.rresp  = addr_ok(s_axi_araddr_i) ? rc_trim_pkg::RESP_OKAY
                                                     : rc_trim_pkg::RESP_SLVERR;
        end else if (st.rvalid && s_axi_rready_i) begin
            next_st.rvalid = 1'b0;
        end
        // Divide by four: toggle every two cycles
        if (rc_mode) begin
            next_st.div_cnt = st.div_cnt + 2'h1;
            if (st.div_cnt[0]) begin
                next_st.quarter_clock = !st.quarter_clock;
            end
        end else begin
            next_st.div_cnt       = 2'h0;
            next_st.quarter_clock = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            st                         <= '0;
            st.rc_trim_calibration     <= rc_trim_pkg::CAL_RESET;
            st.oscillator_select_field <= rc_trim_pkg::OSC_SEL_RESET;
            st.quarter_clock           <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    fine_trim_a: assert property (trim_ctrl_o.fine_trim_code == st.rc_trim_calibration[7:4])
        else $error("fine trim mismatch");
    up_offset_a: assert property (st.rc_trim_calibration[rc_trim_pkg::UP_BIT]
        |-> trim_ctrl_o.coarse == rc_trim_pkg::COARSE_UP)
        else $error("upward offset missing");
    up_clear_a: assert property (!st.rc_trim_calibration[rc_trim_pkg::UP_BIT]
        |-> trim_ctrl_o.coarse != rc_trim_pkg::COARSE_UP)
        else $error("upward offset without bit");
    down_offset_a: assert property ((st.rc_trim_calibration[3:2] == 2'b01)
        |-> trim_ctrl_o.coarse == rc_trim_pkg::COARSE_DOWN)
        else $error("downward offset missing");
    down_clear_a: assert property (!st.rc_trim_calibration[rc_trim_pkg::DOWN_BIT]
        |-> trim_ctrl_o.coarse != rc_trim_pkg::COARSE_DOWN)
        else $error("downward offset without bit");
    up_priority_a: assert property ((st.rc_trim_calibration[3:2] == 2'b11)
        |-> trim_ctrl_o.coarse != rc_trim_pkg::COARSE_DOWN)
        else $error("downward offset not overridden");
    reset_mid_a: assert property (disable iff (1'b0) $rose(rstn_i)
        |-> st.rc_trim_calibration == rc_trim_pkg::CAL_RESET)
        else $error("calibration not at midpoint");
    low_bits_a: assert property (rd_go && s_axi_araddr_i == rc_trim_pkg::CAL_OFFSET
        |=> s_axi_rdata_o[1:0] == 2'b00)
        else $error("low bits read nonzero");
    cal_zero_a: assert property (st.rc_trim_calibration[1:0] == 2'b00)
        else $error("low bits stored");
    quarter_div_a: assert property (rc_mode && $past(rc_mode, 1) && $past(rc_mode, 2)
        && $past(rc_mode, 3) && $past(rc_mode, 4) && $past(rstn_i, 4)
        |-> quarter_clock_output_o == $past(quarter_clock_output_o, 4))
        else $error("quarter clock period wrong");
    quarter_en_a: assert property (quarter_clock_enable_o
        |-> (st.oscillator_select_field == rc_trim_pkg::SEL_INT_RC)
         || (st.oscillator_select_field == rc_trim_pkg::SEL_EXT_RC))
        else $error("clock out enabled outside RC mode");
    mode_gate_a: assert property (!rc_mode |=> !quarter_clock_output_o)
        else $error("clock out outside RC mode");
    reset_low_a: assert property (disable iff (1'b0) !rstn_i |=> !quarter_clock_output_o)
        else $error("clock out high in reset");
    write_next_a: assert property (wr_go && st.aw_addr == rc_trim_pkg::CAL_OFFSET && st.w_strb[0]
        |=> trim_ctrl_o.fine_trim_code == $past(st.w_data[7:4]))
        else $error("write not effective next cycle");

    cover_write_c: cover property (wr_go && st.aw_addr == 12'h000);
    cover_both_c:  cover property (st.rc_trim_calibration[3:2] == 2'b11);
    cover_read_c:  cover property (s_axi_rvalid_o && s_axi_rready_i);
    cover_clk_c:   cover property ($rose(quarter_clock_output_o));
    cover_err_c:   cover property (s_axi_bvalid_o && s_axi_bresp_o == rc_trim_pkg::RESP_SLVERR);

endmodule : rc_oscillator_trim_control

/* File: testbench/tb_rc_oscillator_trim_control.sv */
`timescale 1ns/1ps
module tb_rc_oscillator_trim_control;
    // ==========================================================
    // Signals and model state
    // ==========================================================
    logic                    clk_sys_i = 1'b0;
    logic                    rstn_i    = 1'b0;
    logic [11:0]             awaddr    = 12'h000;
    logic [11:0]             araddr    = 12'h000;
    logic [31:0]             wdata     = 32'h0;
    logic [3:0]              wstrb     = 4'h0;
    logic                    awvalid   = 1'b0;
    logic                    wvalid    = 1'b0;
    logic                    bready    = 1'b0;
    logic                    arvalid   = 1'b0;
    logic                    rready    = 1'b0;
    logic                    awready, wready, bvalid, arready, rvalid, qclk, qen;
    logic [1:0]              bresp, rresp, resp;
    logic [31:0]             rdata, d, v;
    logic [3:0]              hi, rises;
    logic                    prev_q;
    rc_trim_pkg::trim_ctrl_t trim;
    int                      miscompares = 0;
    int                      num_checks  = 0;
    int                      seed        = 32'h6d7d;
    logic [7:0]              cal_m;

    initial forever #5 clk_sys_i = ~clk_sys_i;

    rc_oscillator_trim_control dut (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .trim_ctrl_o(trim), .quarter_clock_output_o(qclk),
        .quarter_clock_enable_o(qen));

    // ==========================================================
    // Bus tasks, model and compare
    // ==========================================================
    task automatic axi_wr(input logic [11:0] a, input logic [7:0] b, input logic [3:0] s);
        logic [31:0] u;
        u = $random(seed);
        @(posedge clk_sys_i);
        awaddr <= a; wdata <= {u[31:8], b}; wstrb <= s;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [11:0] a);
        @(posedge clk_sys_i);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata; resp = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    function automatic logic [5:0] trim_exp(input logic [7:0] c);
        logic [1:0] k;
        k = c[3] ? rc_trim_pkg::COARSE_UP
                 : (c[2] ? rc_trim_pkg::COARSE_DOWN : rc_trim_pkg::COARSE_NONE);
        return {c[7:4], k};
    endfunction : trim_exp

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic count_quarter;
        hi    = 4'h0;
        rises = 4'h0;
        @(negedge clk_sys_i);
        prev_q = qclk;
        repeat (8) begin
            @(negedge clk_sys_i);
            hi     = hi + {3'h0, qclk};
            rises  = rises + {3'h0, qclk & ~prev_q};
            prev_q = qclk;
        end
    endtask : count_quarter

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (5000) @(posedge clk_sys_i);
        miscompares++;
        test_done();
    end

    // ==========================================================
    // Test sequence
    // ==========================================================
    initial begin
        repeat (5) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        cal_m = 8'h70;
        axi_rd(rc_trim_pkg::CAL_OFFSET);
        check("cal reset", 32'h70, d);
        check("trim reset", {26'h0, trim_exp(cal_m)}, {26'h0, trim});
        $display("reset test done");
        for (int i = 0; i < 24; i++) begin
            v = $random(seed);
            v[3:2] = i[1:0];
            // half the writes (i[2] clear) keep bits 1:0 zero
            if (!i[2]) begin
                v[1:0] = 2'h0;
            end
            axi_wr(rc_trim_pkg::CAL_OFFSET, v[7:0], 4'h1);
            check("cal bresp", 32'h0, {30'h0, resp});
            cal_m = v[7:0] & 8'hFC;
            axi_rd(rc_trim_pkg::CAL_OFFSET);
            check("cal read", {24'h0, cal_m}, d);
            check("trim", {26'h0, trim_exp(cal_m)}, {26'h0, trim});
        end
        axi_wr(rc_trim_pkg::CAL_OFFSET, 8'h0C, 4'h0);
        check("strobe bresp", 32'h0, {30'h0, resp});
        axi_wr(12'h00C, 8'h3C, 4'h1);
        check("unmapped bresp", 32'h2, {30'h0, resp});
        axi_rd(12'h00C);
        check("unmapped rresp", 32'h2, {30'h0, resp});
        check("unmapped rdata", 32'h0, d);
        axi_rd(rc_trim_pkg::CAL_OFFSET);
        check("cal kept", {24'h0, cal_m}, d);
        $display("calibration test done");
        // all eight select codes: crystal codes keep clock output off, RC codes 5 and 7 run it
        for (int m = 0; m < 8; m++) begin
            axi_wr(rc_trim_pkg::OSC_SEL_OFFSET, m[7:0], 4'h1);
            axi_rd(rc_trim_pkg::OSC_SEL_OFFSET);
            check("select read", m, d);
            axi_rd(rc_trim_pkg::STATUS_OFFSET);
            check("status", {31'h0, m == 5 || m == 7}, d);
            check("enable", {31'h0, m == 5 || m == 7}, {31'h0, qen});
            count_quarter();
            check("quarter highs", (m == 5 || m == 7) ? 32'h4 : 32'h0, {28'h0, hi});
            check("quarter rises", (m == 5 || m == 7) ? 32'h2 : 32'h0, {28'h0, rises});
        end
        $display("mode test done");
        axi_wr(rc_trim_pkg::CAL_OFFSET, 8'hAC, 4'h1);
        @(posedge clk_sys_i);
        rstn_i <= 1'b0;
        @(posedge clk_sys_i);
        repeat (3) begin
            @(negedge clk_sys_i);
            check("clock in reset", 32'h0, {31'h0, qclk});
        end
        check("trim in reset", {26'h0, trim_exp(8'h70)}, {26'h0, trim});
        @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        count_quarter();
        check("quarter after reset", 32'h4, {28'h0, hi});
        check("rises after reset", 32'h2, {28'h0, rises});
        axi_rd(rc_trim_pkg::CAL_OFFSET);
        check("cal after reset", 32'h70, d);
        $display("reset mid-run test done");
        test_done();
    end
endmodule : tb_rc_oscillator_trim_control
